// [src/sit_core.sv]
// sixteen-bit interval timer with register port and overflow interrupt
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module sit_core
    import sit_pkg::*;
(
    input  wire logic        i_core_clk,  // core clock, 25 MHz
    input  wire logic        i_resetn,    // synchronous reset, active low
    input  wire logic        i_sleep,     // device in sleep
    input  wire sit_bus_s    i_bus,       // register request
    output logic [7:0]       o_rdata,     // read data, cycle after read strobe
    output logic             o_irq,       // overflow interrupt request, level
    output logic [15:0]      o_count      // live counter value
);

    // ************************************************************
    // state
    // ************************************************************
    sit_ctrl_s   ctrl_r;
    logic [15:0] cnt_r;
    logic [2:0]  pre_r;
    logic        gate_r;
    logic        flag_r;
    logic        ie_r;
    logic        peripheral_irq_enable_r;
    logic        gie_r;
    logic        irq_r;
    logic [7:0]  rdata_r;

    logic        sys_tick;
    logic        inst_tick;
    logic        sel_tick;
    logic [2:0]  div_mask;
    logic        pre_hit;
    logic        src_en;
    logic        cnt_inc;
    logic        wrap;
    logic        wr_lo;
    logic        wr_hi;
    logic        wr_cnt;
    logic        wr_ctrl;
    logic        wr_flag;
    logic        wr_pen;
    logic        wr_core;
    logic [7:0]  rd_val;

    // ************************************************************
    // clock source ticks
    // ************************************************************
    sit_tick #(
        .CORE_HZ     (CORE_CLK_HZ),
        .SYS_HZ      (SYS_CLK_HZ)
    ) u_tick (
        .i_core_clk  (i_core_clk),
        .i_resetn    (i_resetn),
        .i_freeze    (i_sleep),
        .o_sys_tick  (sys_tick),
        .o_inst_tick (inst_tick)
    );

    // ************************************************************
    // register decode
    // ************************************************************
    assign wr_lo   = i_bus.wr && i_bus.addr == ADDR_CNT_LO;
    assign wr_hi   = i_bus.wr && i_bus.addr == ADDR_CNT_HI;
    assign wr_cnt  = wr_lo || wr_hi;
    assign wr_ctrl = i_bus.wr && i_bus.addr == ADDR_CTRL;
    assign wr_flag = i_bus.wr && i_bus.addr == ADDR_PFLAG;
    assign wr_pen  = i_bus.wr && i_bus.addr == ADDR_PEN;
    assign wr_core = i_bus.wr && i_bus.addr == ADDR_CORE;

    // ************************************************************
    // source select and prescaler
    // ************************************************************
    assign sel_tick = ctrl_r.clk_sel ? sys_tick : inst_tick;

    always_comb
    begin
        case (ctrl_r.div)
            2'h0:    div_mask = 3'h0;
            2'h1:    div_mask = 3'h1;
            2'h2:    div_mask = 3'h3;
            2'h3:    div_mask = 3'h7;
            default: div_mask = 3'h0;
        endcase
    end

    // sleep is also checked here so a tick issued just before it cannot count
    assign src_en  = ctrl_r.run && gate_r && sel_tick && !i_sleep;
    assign pre_hit = (pre_r & div_mask) == div_mask;
    assign cnt_inc = src_en && pre_hit;
    assign wrap    = cnt_inc && !wr_cnt && cnt_r == CNT_MAX;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
            pre_r <= 3'h0;
        else if (wr_cnt || !ctrl_r.run)
            pre_r <= 3'h0;
        else if (src_en)
            pre_r <= pre_r + 3'h1;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
            gate_r <= 1'b0;
        else
            gate_r <= ctrl_r.run;
    end

    // ************************************************************
    // counter
    // ************************************************************
    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
            cnt_r <= CNT_RST;
        else if (wr_lo)
            cnt_r <= {cnt_r[15:8], i_bus.wdata};
        else if (wr_hi)
            cnt_r <= {i_bus.wdata, cnt_r[7:0]};
        else if (cnt_inc)
            cnt_r <= cnt_r + 16'h1;
    end

    // ************************************************************
    // control and interrupt registers
    // ************************************************************
    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
            ctrl_r <= CTRL_RST;
        else if (wr_ctrl)
        begin
            // unimplemented bits are simply not stored
            ctrl_r.run     <= i_bus.wdata[CTRL_RUN_BIT];
            ctrl_r.clk_sel <= i_bus.wdata[CTRL_CSEL_BIT];
            ctrl_r.div     <= i_bus.wdata[CTRL_DIV_LSB +: 2];
        end
    end

    // a wrap in the clearing cycle keeps the flag set
    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
            flag_r <= 1'b0;
        else if (wrap)
            flag_r <= 1'b1;
        else if (wr_flag && i_bus.wdata[OVF_BIT])
            flag_r <= 1'b0;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            ie_r   <= 1'b0;
            peripheral_irq_enable_r <= 1'b0;
            gie_r  <= 1'b0;
        end
        else
        begin
            if (wr_pen)
                ie_r <= i_bus.wdata[OVF_BIT];
            if (wr_core)
            begin
                peripheral_irq_enable_r <= i_bus.wdata[PERIPHERAL_IRQ_ENABLE_BIT];
                gie_r  <= i_bus.wdata[GIE_BIT];
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
            irq_r <= 1'b0;
        else
            irq_r <= flag_r && ie_r && peripheral_irq_enable_r && gie_r && ctrl_r.run;
    end

    // ************************************************************
    // read port
    // ************************************************************
    always_comb
    begin
        rd_val = BYTE_ZERO;
        case (i_bus.addr)
            ADDR_CNT_LO: rd_val = cnt_r[7:0];
            ADDR_CNT_HI: rd_val = cnt_r[15:8];
            ADDR_CTRL:
            begin
                rd_val[CTRL_RUN_BIT]       = ctrl_r.run;
                rd_val[CTRL_CSEL_BIT]      = ctrl_r.clk_sel;
                rd_val[CTRL_DIV_LSB +: 2]  = ctrl_r.div;
            end
            ADDR_PFLAG:  rd_val[OVF_BIT]  = flag_r;
            ADDR_PEN:    rd_val[OVF_BIT]  = ie_r;
            ADDR_CORE:
            begin
                rd_val[PERIPHERAL_IRQ_ENABLE_BIT] = peripheral_irq_enable_r;
                rd_val[GIE_BIT]  = gie_r;
            end
            default:     rd_val = BYTE_ZERO;
        endcase
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
            rdata_r <= BYTE_ZERO;
        else if (i_bus.rd)
            rdata_r <= rd_val;
        else
            rdata_r <= BYTE_ZERO;
    end

    assign o_rdata = rdata_r;
    assign o_irq   = irq_r;
    assign o_count = cnt_r;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);

    sequence s_lo_write;
        wr_lo;
    endsequence

    sequence s_hi_write;
        wr_hi;
    endsequence

    property p_lo_load;
        s_lo_write
            |=> o_count[7:0] == $past(i_bus.wdata);
    endproperty
    a_lo_load: assert property (p_lo_load)
        else $error("low byte write did not load the counter");

    property p_hi_load;
        s_hi_write
            |=> o_count[15:8] == $past(i_bus.wdata) && $stable(o_count[7:0]);
    endproperty
    a_hi_load: assert property (p_hi_load)
        else $error("high byte write did not load the counter");

    property p_pre_clear;
        wr_cnt |=> pre_r == 3'h0;
    endproperty
    a_pre_clear: assert property (p_pre_clear)
        else $error("prescaler not cleared by counter write");

    sequence s_wrap;
        cnt_inc && !wr_cnt && o_count == CNT_MAX;
    endsequence

    property p_wrap;
        s_wrap |=> (o_count == CNT_RST && flag_r)
            ##1 (flag_r || $past(wr_flag && i_bus.wdata[OVF_BIT]));
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrap did not give zero and set the flag");

    property p_irq_gate;
        (flag_r && ie_r && peripheral_irq_enable_r && gie_r && ctrl_r.run) |=> o_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt missing with all enables set");

    property p_irq_block;
        !(ie_r && peripheral_irq_enable_r && gie_r && ctrl_r.run) |=> !o_irq;
    endproperty
    a_irq_block: assert property (p_irq_block)
        else $error("interrupt raised with an enable clear");

    property p_flag_hold;
        flag_r && !(wr_flag && i_bus.wdata[OVF_BIT]) |=> flag_r;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("overflow flag dropped without software clear");

    property p_sleep_freeze;
        i_sleep && !wr_cnt |=> $stable(o_count);
    endproperty
    a_sleep_freeze: assert property (p_sleep_freeze)
        else $error("counter moved during sleep");

    property p_off_stop;
        !ctrl_r.run |=> !gate_r && ($stable(o_count) || $past(wr_cnt));
    endproperty
    a_off_stop: assert property (p_off_stop)
        else $error("counter moved or gate set while stopped");

    property p_fast_count;
        sys_tick && ctrl_r.clk_sel && ctrl_r.div == 2'h0 && ctrl_r.run && gate_r
            && !i_sleep && !wr_cnt |=> o_count == $past(o_count) + 16'h1;
    endproperty
    a_fast_count: assert property (p_fast_count)
        else $error("system clock tick at 1:1 did not count");

    property p_ctrl_rsv;
        i_bus.rd && i_bus.addr == ADDR_CTRL |=> o_rdata[7:6] == 2'h0 && o_rdata[3:2] == 2'h0;
    endproperty
    a_ctrl_rsv: assert property (p_ctrl_rsv)
        else $error("unimplemented control bits read non-zero");

endmodule

// [src/sit_pkg.sv]
// package: register map, field layout, rates and bus carrier of the interval timer
// Notes on behaviour
// - 16-bit counter; byte writes load it live
// - select bit picks system or instruction clock
// - two-bit field divides by 1, 2, 4, 8
// - prescaler hidden; counter byte write clears it
// - FFFFh wraps to 0000h, sets overflow flag
// - request needs run, enable, peripheral, global bits
// - flag stays set until software clears it
// - internal clocks only; frozen, never wakes, in sleep
// - run bit low stops count, clears gate
// - system clock, 1:1 gives four counts per instruction
// - control bits 7:6, 3:2 read zero, ignore writes
package sit_pkg;

    // ************************************************************
    // rates
    // ************************************************************
    localparam int unsigned CORE_CLK_HZ = 25_000_000;
    localparam int unsigned SYS_CLK_HZ  = 8_000_000;
    localparam int unsigned INST_DIV    = 4;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam int          ADDR_W      = 4;
    localparam logic [3:0]  ADDR_CNT_LO = 4'h0;
    localparam logic [3:0]  ADDR_CNT_HI = 4'h1;
    localparam logic [3:0]  ADDR_CTRL   = 4'h2;
    localparam logic [3:0]  ADDR_PFLAG  = 4'h3;
    localparam logic [3:0]  ADDR_PEN    = 4'h4;
    localparam logic [3:0]  ADDR_CORE   = 4'h5;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int          CTRL_RUN_BIT  = 0;
    localparam int          CTRL_CSEL_BIT = 1;
    localparam int          CTRL_DIV_LSB  = 4;
    localparam int          OVF_BIT       = 0;
    localparam int          PERIPHERAL_IRQ_ENABLE_BIT      = 6;
    localparam int          GIE_BIT       = 7;
    localparam logic [15:0] CNT_MAX       = 16'hFFFF;
    localparam logic [15:0] CNT_RST       = 16'h0000;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [1:0] div;
        logic       clk_sel;
        logic       run;
    } sit_ctrl_s;

    localparam sit_ctrl_s CTRL_RST = '{div: 2'h0, clk_sel: 1'b0, run: 1'b0};

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } sit_bus_s;

endpackage

// [src/sit_tick.sv]
// system and instruction clock ticks derived from the core clock
`timescale 1ns/1ps
module sit_tick
    import sit_pkg::*;
#(
    parameter int unsigned CORE_HZ = CORE_CLK_HZ,
    parameter int unsigned SYS_HZ  = SYS_CLK_HZ
)(
    input  wire logic i_core_clk,  // core clock
    input  wire logic i_resetn,    // synchronous reset, active low
    input  wire logic i_freeze,    // sleep: no ticks
    output logic      o_sys_tick,  // one pulse per system clock
    output logic      o_inst_tick  // one pulse per instruction clock
);
    if (SYS_HZ == 0 || SYS_HZ > CORE_HZ)
    begin : g_chk
        $error("system clock rate must lie between 1 and the core rate");
    end

    localparam logic [31:0] STEP = 32'(SYS_HZ);
    localparam logic [31:0] WRAP = 32'(CORE_HZ);
    localparam logic [1:0]  PH_LAST = 2'(INST_DIV - 1);

    logic [31:0] acc_r;
    logic [1:0]  ph_r;

    // ************************************************************
    // fractional phase accumulator
    // ************************************************************
    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            acc_r       <= 32'h0;
            ph_r        <= 2'h0;
            o_sys_tick  <= 1'b0;
            o_inst_tick <= 1'b0;
        end
        else if (i_freeze)
        begin
            o_sys_tick  <= 1'b0;
            o_inst_tick <= 1'b0;
        end
        else if (acc_r + STEP >= WRAP)
        begin
            acc_r       <= acc_r + STEP - WRAP;
            ph_r        <= ph_r + 2'h1;
            o_sys_tick  <= 1'b1;
            o_inst_tick <= (ph_r == PH_LAST);
        end
        else
        begin
            acc_r       <= acc_r + STEP;
            o_sys_tick  <= 1'b0;
            o_inst_tick <= 1'b0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    logic [2:0] hcnt_r;
    always_ff @(posedge i_core_clk)
    begin
        // starts at one so the first quarter after reset counts like the others
        if (!i_resetn)
            hcnt_r <= 3'h1;
        else if (o_inst_tick)
            hcnt_r <= 3'h1;
        else if (o_sys_tick)
            hcnt_r <= hcnt_r + 3'h1;
    end

    property p_inst_quarter;
        @(posedge i_core_clk) disable iff (!i_resetn)
        o_inst_tick |-> o_sys_tick && hcnt_r == 3'h4;
    endproperty
    a_inst_quarter: assert property (p_inst_quarter)
        else $error("instruction tick not on every fourth system tick");

endmodule

// [sim/tb_top.sv]
// self-checking bench for the sixteen-bit interval timer
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module tb_top;
    import sit_pkg::*;

    // ************************************************************
    // clock, reset, design
    // ************************************************************
    logic        i_core_clk = 1'b0;
    logic        i_resetn   = 1'b0;
    logic        i_sleep    = 1'b0;
    sit_bus_s    bus        = '0;
    logic [7:0]  o_rdata;
    logic        o_irq;
    logic [15:0] o_count;
    int          err_total  = 0;
    int          num_checks = 0;
    int          cycles     = 0;
    logic [7:0]  rd;
    logic [15:0] snap;
    longint      expn;
    int          n;

    always #20 i_core_clk = ~i_core_clk;

    sit_core i_sit_core (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_sleep    (i_sleep),
        .i_bus      (bus),
        .o_rdata    (o_rdata),
        .o_irq      (o_irq),
        .o_count    (o_count)
    );

    // ************************************************************
    // bus tasks and closing
    // ************************************************************
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge i_core_clk);
        bus.wr    <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_core_clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge i_core_clk);
        bus.rd   <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    task automatic wait_cyc(input int k);
        repeat (k) @(posedge i_core_clk);
        #1;
    endtask

    task automatic complete_run;
        if (err_total == 0 && num_checks > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge i_core_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            err_total++;
            complete_run();
        end
    end

    // ************************************************************
    // tests
    // ************************************************************
    logic [3:0] off_a [4] = '{ADDR_CORE, ADDR_CORE, ADDR_PEN, ADDR_CTRL};
    logic [7:0] off_d [4] = '{8'h40, 8'h80, 8'h00, 8'h02};
    logic [3:0] on_a  [4] = '{ADDR_CORE, ADDR_CORE, ADDR_PEN, ADDR_CTRL};
    logic [7:0] on_d  [4] = '{8'hC0, 8'hC0, 8'h01, 8'h03};

    initial
    begin
        repeat (6) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        wait_cyc(1);
        `CHK("count_rst", 16'h0000, o_count)
        `CHK("irq_rst", 1'b0, o_irq)
        for (int a = 0; a < 6; a++)
        begin
            rd_reg(a[3:0], rd);
            `CHK("reg_rst", 8'h00, rd)
        end
        rd_reg(4'hF, rd);
        `CHK("unmapped", 8'h00, rd)
        // unimplemented control bits
        wr_reg(ADDR_CTRL, 8'hCC);
        rd_reg(ADDR_CTRL, rd);
        `CHK("ctrl_resv", 8'h00, rd)
        wr_reg(ADDR_CTRL, 8'hFE);
        rd_reg(ADDR_CTRL, rd);
        `CHK("ctrl_bits", 8'h32, rd)
        // byte loads while stopped
        wr_reg(ADDR_CNT_LO, 8'hAB);
        wr_reg(ADDR_CNT_HI, 8'hCD);
        `CHK("count_load", 16'hCDAB, o_count)
        wait_cyc(100);
        `CHK("count_stop", 16'hCDAB, o_count)
        rd_reg(ADDR_CNT_LO, rd);
        `CHK("lo_read", 8'hAB, rd)
        rd_reg(ADDR_CNT_HI, rd);
        `CHK("hi_read", 8'hCD, rd)
        // rates for both clocks and all dividers
        for (int s = 0; s < 2; s++)
        begin
            for (int dv = 0; dv < 4; dv++)
            begin
                wr_reg(ADDR_CNT_LO, 8'h00);
                wr_reg(ADDR_CNT_HI, 8'h00);
                wr_reg(ADDR_CTRL, {2'b00, dv[1:0], 2'b00, s[0], 1'b1});
                repeat (4000) @(posedge i_core_clk);
                wr_reg(ADDR_CTRL, 8'h00);
                expn = (longint'(4002) * SYS_CLK_HZ / CORE_CLK_HZ) / (s ? 1 : INST_DIV) >> dv;
                n = int'(o_count) - int'(expn);
                `CHK("rate", 1'b1, (n >= -3 && n <= 3))
            end
        end
        // counter write restarts the prescaler
        wr_reg(ADDR_CTRL, 8'h33);
        for (int i = 0; i < 20; i++)
        begin
            wr_reg(ADDR_CNT_LO, 8'h00);
            wait_cyc(15);
            `CHK("psc_clear", 16'h0000, o_count)
        end
        // frozen in sleep
        wr_reg(ADDR_CTRL, 8'h03);
        @(posedge i_core_clk);
        i_sleep <= 1'b1;
        wait_cyc(2);
        snap = o_count;
        wait_cyc(300);
        `CHK("sleep_hold", snap, o_count)
        @(posedge i_core_clk);
        i_sleep <= 1'b0;
        wait_cyc(50);
        `CHK("sleep_wake", 1'b1, (o_count != snap))
        // overflow, flag and request chain
        wr_reg(ADDR_CTRL, 8'h00);
        wr_reg(ADDR_CNT_LO, 8'hF0);
        wr_reg(ADDR_CNT_HI, 8'hFF);
        wr_reg(ADDR_PFLAG, 8'h01);
        wr_reg(ADDR_PEN, 8'h01);
        wr_reg(ADDR_CORE, 8'hC0);
        `CHK("irq_idle", 1'b0, o_irq)
        wr_reg(ADDR_CTRL, 8'h03);
        for (int i = 0; i < 200 && o_irq !== 1'b1; i++)
            wait_cyc(1);
        `CHK("irq_wrap", 1'b1, o_irq)
        `CHK("wrap_low", 1'b1, (o_count < 16'h0010))
        rd_reg(ADDR_PFLAG, rd);
        `CHK("flag_set", 8'h01, rd)
        for (int k = 0; k < 4; k++)
        begin
            wr_reg(off_a[k], off_d[k]);
            wait_cyc(2);
            `CHK("irq_masked", 1'b0, o_irq)
            rd_reg(ADDR_PFLAG, rd);
            `CHK("flag_kept", 8'h01, rd)
            wr_reg(on_a[k], on_d[k]);
            wait_cyc(2);
            `CHK("irq_back", 1'b1, o_irq)
        end
        wait_cyc(300);
        wr_reg(ADDR_PFLAG, 8'h00);
        rd_reg(ADDR_PFLAG, rd);
        `CHK("flag_w0", 8'h01, rd)
        wr_reg(ADDR_PFLAG, 8'h01);
        rd_reg(ADDR_PFLAG, rd);
        `CHK("flag_clr", 8'h00, rd)
        wait_cyc(2);
        `CHK("irq_clr", 1'b0, o_irq)
        complete_run();
    end
endmodule
